/* core/mfidec_pkg.sv */
// package for the multi-function input decoder: register map, resets, codes
// assumes a 50 MHz system clock and a 32-bit AXI4-Lite register port
package mfidec_pkg;
   // register byte offsets (one aligned word each)
   localparam logic [7:0] OFS_FSEL0     = 8'h00; // terminal1..8 at +4 steps
   localparam logic [7:0] OFS_CTRL      = 8'h20; // mode and source settings
   localparam logic [7:0] OFS_LIMITS    = 8'h24; // upper [15:0], lower [31:16]
   localparam logic [7:0] OFS_ANALOG    = 8'h28; // analog lower value [15:0]
   localparam logic [7:0] OFS_STEP      = 8'h2c; // up/down step [15:0]
   localparam logic [7:0] OFS_STATUS    = 8'h30; // block state, read only
   localparam logic [7:0] OFS_UPDN      = 8'h34; // up/down frequency, ro
   localparam logic [7:0] OFS_PRESET0   = 8'h40; // presets 0..15, jog at 16
   localparam int         NUM_TERM      = 8;
   localparam int         NUM_PRESET    = 17;
   localparam int         JOG_IDX       = 16;
   // ctrl field positions
   localparam int CTRL_PWRUP_ACCEPT = 0;
   localparam int CTRL_HOLD_EN      = 1;
   localparam int CTRL_ANALOG_SEL2  = 2;
   localparam int CTRL_KEY_LOCAL    = 3;
   localparam int CTRL_FSRC1_LSB    = 8;  // freq_source_sel_one [11:8]
   localparam int CTRL_FSRC2_LSB    = 12; // freq_source_sel_two [15:12]
   localparam int CTRL_RSRC1_LSB    = 16; // run_source_sel_one [19:16]
   localparam int CTRL_RSRC2_LSB    = 20; // run_source_sel_two [23:20]
   // reset values
   localparam logic [7:0] FSEL_RST [NUM_TERM] =
      '{8'h00, 8'h01, 8'h17, 8'h27, 8'h05, 8'h06, 8'h09, 8'h13};
   localparam logic [31:0] CTRL_RST   = 32'h0000_0000;
   localparam logic [31:0] LIMIT_RST  = 32'h0000_ffff;
   localparam logic [15:0] STEP_RST   = 16'h0001;
   // function codes
   localparam logic [7:0] FN_MAX      = 8'h49; // 73
   localparam logic [7:0] FN_3WIRE    = 8'h02;
   localparam logic [7:0] FN_LOCREM   = 8'h03;
   localparam logic [7:0] FN_SRCSEL   = 8'h04;
   localparam logic [7:0] FN_STEP1    = 8'h05;
   localparam logic [7:0] FN_JOG      = 8'h09;
   localparam logic [7:0] FN_UP       = 8'h0a;
   localparam logic [7:0] FN_DOWN     = 8'h0b;
   localparam logic [3:0] FSRC_UPDN   = 4'h2;
   // timing
   localparam int CLK_HZ       = 50_000_000;
   localparam int RUN_MIN_US   = 2000; // run contact held more than 2 ms
   localparam int RUN_CYC      = RUN_MIN_US * (CLK_HZ / 1_000_000);
   localparam int TICK_US      = 10000; // up/down step interval
   localparam int TICK_CYC_DEF = TICK_US * (CLK_HZ / 1_000_000);
   localparam int FLASH_TICKS  = 16;   // indicator half period, in ticks
   // three-wire sequencing states
   typedef enum logic [1:0] {
      SEQ_STOP  = 2'b00,
      SEQ_ARMED = 2'b01,
      SEQ_RUN   = 2'b11
   } mfidec_seq_t;
endpackage

/* core/mfidec_top.sv */
// multi-function digital input decoder with AXI4-Lite register port
// assumes raw contact inputs asynchronous to clk_sys; one clock domain
// Operation
// - eight terminals, each coded 0 to 73
// - reset codes 0,1,23,39,5,6,9,19
// - code 2 makes terminals one/two run/stop
// - three-wire run after more than 2 ms
// - stop terminal open stops immediately
// - direction open forward, closed reverse
// - run at power-up rejected; accept bit seen only at its reset value 0
// - code 3 closed means local keypad
// - remote uses set one without code 4
// - keypad key ignored when a terminal has code 3; local indicator lit
// - local/remote change deferred while running
// - code 4 picks source set, frozen running
// - codes 5-8 select sixteen presets
// - jog closed uses jog preset; ramps only stored
// - up/down needs 10, 11, source 2
// - up raises, down lowers, else hold
// - lone up or down raises alarm
// - hold off clears up/down at stop
// - hold on clears only on stopped press
// - clamp up/down between limits, analog min
module mfidec_top
   import mfidec_pkg::*;
#(
   parameter int RUN_CYCLES  = RUN_CYC,      // run qualify count
   parameter int TICK_CYCLES = TICK_CYC_DEF  // up/down step interval
) (
   // clock and reset
   input  wire logic        clk_sys,
   input  wire logic        nrst,
   // raw terminal contacts, 1 = closed
   input  wire logic [7:0]  term_in,
   // drive state
   input  wire logic        drive_running,
   input  wire logic        two_wire_run,
   // axi4-lite write address
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   // axi4-lite write data
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   // axi4-lite write response
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // axi4-lite read
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // drive commands
   output logic             run_cmd,
   output logic             reverse_cmd,
   output logic             local_mode,
   output logic             local_led,
   output logic             source_set_two,
   output logic [3:0]       freq_source_sel,
   output logic [3:0]       run_source_sel,
   output logic [15:0]      freq_cmd,
   output logic             jog_active,
   output logic             input_select_error_alarm,
   output logic             powerup_fault,
   output logic             fault_led_flash
);

   // masks the 8-bit wstrb-selected update of a word
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0]  be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) r[8*i +: 8] = nw[8*i +: 8];
      end
      return r;
   endfunction

   // 1 for each terminal holding a given code
   function automatic logic [7:0] hits(input logic [7:0] sel [NUM_TERM],
                                       input logic [7:0] code);
      logic [7:0] h;
      h = 8'h00;
      for (int i = 0; i < NUM_TERM; i++) h[i] = (sel[i] == code);
      return h;
   endfunction

   // -------- registers --------
   logic [7:0]  fsel_r   [NUM_TERM];    // function codes
   logic [15:0] preset_r [NUM_PRESET];  // presets and jog
   logic [31:0] ctrl_r;                 // mode settings
   logic [31:0] limits_r;               // upper/lower limit
   logic [15:0] analog_r;               // analog lower value
   logic [15:0] step_r;                 // up/down step size
   logic [31:0] jog_ramp_r;             // jog accel [15:0], decel [31:16]

   // -------- input synchroniser --------
   logic [7:0] sync1_r, sync2_r;        // sync1_r feeds sync2_r only
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         sync1_r <= 8'h00;
         sync2_r <= 8'h00;
      end else begin
         sync1_r <= term_in;
         sync2_r <= sync1_r;
      end
   end

   // -------- function decode --------
   wire [7:0] h_3w   = hits(fsel_r, FN_3WIRE) & 8'hfc;
   wire [7:0] h_lr   = hits(fsel_r, FN_LOCREM);
   wire [7:0] h_src  = hits(fsel_r, FN_SRCSEL);
   wire [7:0] h_jog  = hits(fsel_r, FN_JOG);
   wire [7:0] h_up   = hits(fsel_r, FN_UP);
   wire [7:0] h_dn   = hits(fsel_r, FN_DOWN);
   wire       three_wire = |h_3w;
   wire       run_in  = sync2_r[0];
   wire       stop_in = sync2_r[1];                           // 1 = closed
   wire       dir_in  = |(h_3w & sync2_r);
   wire       lr_in   = |(h_lr & sync2_r);
   wire       src_in  = |(h_src & sync2_r);
   wire       jog_in  = |(h_jog & sync2_r);
   wire       up_in   = |(h_up & sync2_r);
   wire       dn_in   = |(h_dn & sync2_r);
   wire       up_asg  = |h_up;
   wire       dn_asg  = |h_dn;
   wire       pair_err = up_asg ^ dn_asg;

   // multi-step index, unassigned step reads zero
   logic [3:0] step_idx;
   always_comb begin
      step_idx = 4'h0;
      for (int b = 0; b < 4; b++) begin
         step_idx[b] = |(hits(fsel_r, FN_STEP1 + 8'(b)) & sync2_r);
      end
   end

   // -------- three-wire sequencing --------
   mfidec_seq_t seq_r, seq_nxt;
   logic [31:0] run_cnt_r;              // run closed duration
   logic        first_r;                // first cycle after reset
   logic        pu_block_r;             // power-up run being ignored
   logic [31:0] blink_cnt_r;            // flash timer, slow enough to see
   wire         run_req = three_wire ? (seq_r == SEQ_RUN) : two_wire_run;

   always_comb begin
      seq_nxt = seq_r;
      case (seq_r)
         SEQ_STOP:  if (run_in && stop_in) seq_nxt = SEQ_ARMED;
         SEQ_ARMED: begin
            if (!stop_in || !run_in) seq_nxt = SEQ_STOP;
            else if (run_cnt_r >= 32'(RUN_CYCLES)) seq_nxt = SEQ_RUN;
         end
         SEQ_RUN:   if (!stop_in) seq_nxt = SEQ_STOP;
         default:   seq_nxt = SEQ_STOP;
      endcase
      if (!three_wire || pu_block_r) seq_nxt = SEQ_STOP;
   end

   // sequencer state and run-duration counter
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         seq_r     <= SEQ_STOP;
         run_cnt_r <= 32'h0;
      end else begin
         seq_r     <= seq_nxt;
         run_cnt_r <= (seq_r == SEQ_ARMED) ? run_cnt_r + 32'h1 : 32'h0;
      end
   end

   // power-up run check: a run present at the first look is blocked
   // until it is released; acceptance is read only in the first cycle, at its reset value 0
   wire pu_run_seen = three_wire ? run_in : two_wire_run;
   wire blink_wrap  = blink_cnt_r >= 32'(2 * FLASH_TICKS * TICK_CYCLES - 1);
   wire blink_on    = blink_cnt_r < 32'(FLASH_TICKS * TICK_CYCLES);
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         first_r     <= 1'b1;
         pu_block_r  <= 1'b0;
         blink_cnt_r <= 32'h0;
      end else begin
         first_r <= 1'b0;
         blink_cnt_r <= blink_wrap ? 32'h0 : blink_cnt_r + 32'h1;
         if (first_r)
            pu_block_r <= pu_run_seen && !ctrl_r[CTRL_PWRUP_ACCEPT];
         else if (!pu_run_seen)
            pu_block_r <= 1'b0;
      end
   end

   // -------- location and source --------
   logic loc_r, set2_r;
   wire  loc_want = (|h_lr) ? lr_in : ctrl_r[CTRL_KEY_LOCAL];
   wire  set2_want = (|h_src) & src_in;
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         loc_r  <= 1'b0;
         set2_r <= 1'b0;
      end else if (!drive_running) begin
         loc_r  <= loc_want;
         set2_r <= set2_want;
      end
   end
   wire [3:0] fsrc = set2_r ? ctrl_r[CTRL_FSRC2_LSB +: 4]
                            : ctrl_r[CTRL_FSRC1_LSB +: 4];
   wire [3:0] rsrc = set2_r ? ctrl_r[CTRL_RSRC2_LSB +: 4]
                            : ctrl_r[CTRL_RSRC1_LSB +: 4];

   // -------- up/down accumulator --------
   logic [15:0] updn_r;
   logic [31:0] tick_cnt_r;
   wire  updn_en = up_asg & dn_asg & (fsrc == FSRC_UPDN) & !loc_r;
   wire  tick    = (tick_cnt_r >= 32'(TICK_CYCLES - 1));
   wire  inc     = up_in & !dn_in;
   wire  dec     = dn_in & !up_in;
   wire [15:0] upper = limits_r[15:0];
   wire [15:0] lo_set = limits_r[31:16];
   wire [15:0] lower = (ctrl_r[CTRL_ANALOG_SEL2] && analog_r < lo_set) ?
                       analog_r : lo_set;
   wire [16:0] sum  = {1'b0, updn_r} + {1'b0, step_r};
   wire [15:0] diff = (updn_r > step_r) ? updn_r - step_r : 16'h0;
   logic [15:0] updn_nxt;
   always_comb begin
      updn_nxt = updn_r;
      if (!run_req && !ctrl_r[CTRL_HOLD_EN])
         updn_nxt = 16'h0;
      else if (!run_req && (up_in || dn_in))
         updn_nxt = 16'h0;
      else if (run_req && tick && inc)
         updn_nxt = sum[16] ? 16'hffff : sum[15:0];
      else if (run_req && tick && dec)
         updn_nxt = diff;
      if (run_req) begin
         if (updn_nxt > upper) updn_nxt = upper;
         if (updn_nxt < lower) updn_nxt = lower;
      end
   end
   // accumulator and its step timer
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         updn_r     <= 16'h0;
         tick_cnt_r <= 32'h0;
      end else begin
         updn_r     <= updn_en ? updn_nxt : 16'h0;
         tick_cnt_r <= (tick || !(inc || dec)) ? 32'h0 : tick_cnt_r + 32'h1;
      end
   end

   // -------- command outputs, registered except the source selects --------
   wire [15:0] freq_sel = jog_in  ? preset_r[JOG_IDX] :
                          updn_en ? updn_r : preset_r[step_idx];
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         run_cmd <= 1'b0; reverse_cmd <= 1'b0; freq_cmd <= 16'h0;
         jog_active <= 1'b0; input_select_error_alarm <= 1'b0;
         powerup_fault <= 1'b0; fault_led_flash <= 1'b0;
      end else begin
         run_cmd     <= run_req & !pu_block_r & !first_r;
         reverse_cmd <= three_wire & dir_in;
         freq_cmd    <= freq_sel;
         jog_active  <= jog_in;
         input_select_error_alarm <= pair_err;
         powerup_fault   <= pu_block_r;
         fault_led_flash <= pu_block_r & blink_on;
      end
   end
   assign local_mode      = loc_r;
   assign local_led       = loc_r;
   assign source_set_two  = set2_r;
   assign freq_source_sel = fsrc;
   assign run_source_sel  = rsrc;

   // -------- axi4-lite slave --------
   logic aw_held_r, w_held_r;
   logic [7:0]  awaddr_r;
   logic [31:0] wdata_r;
   logic [3:0]  wstrb_r;
   assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
   assign s_axi_wready  = !w_held_r && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;
   wire do_wr = aw_held_r && w_held_r;
   wire [7:0]  wa = awaddr_r;
   wire        wa_fsel   = wa < OFS_CTRL;
   wire        wa_preset = wa >= OFS_PRESET0 && wa < OFS_PRESET0 + 8'h44;
   wire        wa_jogr   = wa == OFS_PRESET0 + 8'h44;
   wire [4:0]  widx      = 5'(wa[7:2]) - 5'(OFS_PRESET0[7:2]);
   wire [31:0] wv = merge(32'h0, wdata_r, wstrb_r);

   // write channel capture and register update
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         aw_held_r <= 1'b0; w_held_r <= 1'b0; s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'b00; awaddr_r <= 8'h00; wdata_r <= 32'h0;
         wstrb_r <= 4'h0; ctrl_r <= CTRL_RST; limits_r <= LIMIT_RST;
         analog_r <= 16'h0; step_r <= STEP_RST; jog_ramp_r <= 32'h0;
         for (int i = 0; i < NUM_TERM; i++) fsel_r[i] <= FSEL_RST[i];
         for (int i = 0; i < NUM_PRESET; i++) preset_r[i] <= 16'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_r <= 1'b1; awaddr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_r <= 1'b1; wdata_r <= s_axi_wdata; wstrb_r <= s_axi_wstrb;
         end
         if (s_axi_bvalid && s_axi_bready) s_axi_bvalid <= 1'b0;
         if (do_wr) begin
            aw_held_r <= 1'b0; w_held_r <= 1'b0; s_axi_bvalid <= 1'b1;
            s_axi_bresp <= 2'b00;
            if (wa_fsel) begin
               // out-of-range codes are refused, slverr
               if (wstrb_r[0] && wdata_r[7:0] <= FN_MAX)
                  fsel_r[wa[4:2]] <= wdata_r[7:0];
               else if (wstrb_r[0]) s_axi_bresp <= 2'b10;
            end else if (wa == OFS_CTRL)
               ctrl_r <= merge(ctrl_r, wdata_r, wstrb_r);
            else if (wa == OFS_LIMITS)
               limits_r <= merge(limits_r, wdata_r, wstrb_r);
            else if (wa == OFS_ANALOG) analog_r <= wv[15:0];
            else if (wa == OFS_STEP) step_r <= wv[15:0];
            else if (wa_preset) preset_r[widx] <= wv[15:0];
            else if (wa_jogr) jog_ramp_r <= merge(jog_ramp_r, wdata_r, wstrb_r);
            else s_axi_bresp <= 2'b10;
         end
      end
   end

   // read decode
   wire [7:0] ra = s_axi_araddr;
   wire [4:0] ridx = 5'(ra[7:2]) - 5'(OFS_PRESET0[7:2]);
   wire [31:0] status_w = {16'h0, step_idx, 1'b0, powerup_fault,
                           input_select_error_alarm, jog_active,
                           set2_r, loc_r, reverse_cmd, run_cmd,
                           sync2_r[7:4] & 4'hf};
   logic [31:0] rd;
   logic        rd_ok;
   always_comb begin
      rd_ok = 1'b1;
      rd    = 32'h0;
      if (ra < OFS_CTRL)        rd = {24'h0, fsel_r[ra[4:2]]};
      else if (ra == OFS_CTRL)  rd = ctrl_r;
      else if (ra == OFS_LIMITS) rd = limits_r;
      else if (ra == OFS_ANALOG) rd = {16'h0, analog_r};
      else if (ra == OFS_STEP)  rd = {16'h0, step_r};
      else if (ra == OFS_STATUS) rd = status_w;
      else if (ra == OFS_UPDN)  rd = {16'h0, updn_r};
      else if (ra >= OFS_PRESET0 && ra < OFS_PRESET0 + 8'h44)
         rd = {16'h0, preset_r[ridx]};
      else if (ra == OFS_PRESET0 + 8'h44) rd = jog_ramp_r;
      else rd_ok = 1'b0;
   end
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         s_axi_rvalid <= 1'b0; s_axi_rdata <= 32'h0; s_axi_rresp <= 2'b00;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rd;
         s_axi_rresp  <= rd_ok ? 2'b00 : 2'b10;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // -------- assertions --------
   a_stop_immediate: assert property (@(posedge clk_sys) disable iff (!nrst)
      (seq_r == SEQ_RUN && !stop_in) |=> seq_r == SEQ_STOP)
      else $error("stop open did not stop");
   a_run_qualify: assert property (@(posedge clk_sys) disable iff (!nrst)
      $rose(seq_r == SEQ_RUN) |-> $past(run_cnt_r) >= 32'(RUN_CYCLES))
      else $error("run started before qualify time");
   a_loc_frozen: assert property (@(posedge clk_sys) disable iff (!nrst)
      $past(drive_running) |-> $stable(loc_r) && $stable(set2_r))
      else $error("location changed while running");
   a_pair_alarm: assert property (@(posedge clk_sys) disable iff (!nrst)
      (up_asg != dn_asg) |=> input_select_error_alarm)
      else $error("lone up/down not flagged");
   a_updn_clear: assert property (@(posedge clk_sys) disable iff (!nrst)
      (!run_req && !ctrl_r[CTRL_HOLD_EN]) |=> updn_r == 16'h0)
      else $error("up/down kept after stop");
   a_jog_freq: assert property (@(posedge clk_sys) disable iff (!nrst)
      jog_in |=> freq_cmd == $past(preset_r[JOG_IDX]))
      else $error("jog preset not used");
   a_dir_map: assert property (@(posedge clk_sys) disable iff (!nrst)
      three_wire |=> reverse_cmd == $past(dir_in))
      else $error("direction mismatch");
   a_pu_block: assert property (@(posedge clk_sys) disable iff (!nrst)
      (pu_block_r || first_r) |=> !run_cmd)
      else $error("power-up run not ignored");
endmodule

/* sim/mfidec_contacts.sv */
// external switch contacts in front of the eight input terminals
// assumes the bench sets the wanted contact state just after a clock edge
module mfidec_contacts #(
   parameter int HOLD = 6  // minimum made time of the run contact
) (
   // clock
   input  wire logic       clk_sys,
   // wanted contact state, 1 = closed
   input  wire logic [7:0] req,
   // contact levels seen by the decoder
   output logic [7:0]      term_in
);
   timeunit 1ns;
   timeprecision 100ps;
   int held;  // cycles the run contact has been made

   initial term_in = 8'h00;

   // contacts follow the request, but a made run contact is never
   // let go before its minimum time: a short blip would not start
   always @(posedge clk_sys) begin
      if (term_in[0] && !req[0] && held < HOLD) begin
         term_in <= {req[7:1], 1'b1};
      end else begin
         term_in <= req;
      end
      held <= term_in[0] ? held + 1 : 0;
   end
endmodule

/* sim/tb.sv */
// self-checking bench for the input decoder, register port and terminals
// assumes short run and tick counts set by parameter below
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   import mfidec_pkg::*;
   logic        clk_sys, nrst, drive_running, two_wire_run;
   logic [7:0]  req, term_in, awaddr, araddr;  // contacts and addresses
   logic [31:0] wdata, rdata;
   logic        awv, wv, bready, arv, rready;  // bus requests
   logic        awready, wready, bvalid, arready, rvalid;
   logic [1:0]  bresp, rresp;
   logic        run_cmd, reverse_cmd, local_mode, local_led, set2;
   logic        jog, alarm, pufault, flash;
   logic [1:0]  seen;  // flash levels observed
   logic [3:0]  fsrc, rsrc;
   logic [15:0] freq;
   int          n_errors, checks, i;

   mfidec_top #(.RUN_CYCLES(5), .TICK_CYCLES(4)) uut (
      .clk_sys(clk_sys), .nrst(nrst), .term_in(term_in),
      .drive_running(drive_running), .two_wire_run(two_wire_run),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awv), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arv),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .run_cmd(run_cmd),
      .reverse_cmd(reverse_cmd), .local_mode(local_mode),
      .local_led(local_led), .source_set_two(set2),
      .freq_source_sel(fsrc), .run_source_sel(rsrc), .freq_cmd(freq),
      .jog_active(jog), .input_select_error_alarm(alarm),
      .powerup_fault(pufault), .fault_led_flash(flash));

   mfidec_contacts #(.HOLD(6)) sw (.clk_sys(clk_sys), .req(req),
      .term_in(term_in));

   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end

   task automatic summarize;
      $display("checks %0d n_errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // compare seen against expected, four-state
   task automatic chk(input string s, input logic [31:0] got, exp);
      checks++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch %s exp %h got %h", s, exp, got);
      end
   endtask

   task automatic cyc(input int k);
      repeat (k) @(posedge clk_sys);
   endtask

   // one write; address and data offered together, each dropped when taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] er);
      int n;
      @(posedge clk_sys);
      awaddr <= a; wdata <= d; awv <= 1'b1; wv <= 1'b1; bready <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(posedge clk_sys);
         if (awv & awready) awv <= 1'b0;
         if (wv & wready) wv <= 1'b0;
         if (bvalid) break;
      end
      bready <= 1'b0;
      chk("bresp", bresp, er);
      if (n == 40) begin
         n_errors++;
         summarize();
      end
   endtask

   // one read, data and response checked
   task automatic rd(input logic [7:0] a, input logic [31:0] ed,
                     input logic [1:0] er);
      int n;
      @(posedge clk_sys);
      araddr <= a; arv <= 1'b1; rready <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(posedge clk_sys);
         if (arv & arready) arv <= 1'b0;
         if (rvalid) break;
      end
      rready <= 1'b0;
      chk($sformatf("rdata %h", a), rdata, ed);
      chk("rresp", rresp, er);
      if (n == 40) begin
         n_errors++;
         summarize();
      end
   endtask

   initial begin
      nrst = 1'b0; drive_running = 1'b0; two_wire_run = 1'b1; req = 8'h00;
      awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0; awv = 1'b0;
      wv = 1'b0; bready = 1'b0; arv = 1'b0; rready = 1'b0;
      n_errors = 0; checks = 0;
      seen = 2'b00;
      cyc(10);
      nrst <= 1'b1;
      // run request already present at power-up is refused
      cyc(6);
      chk("pufault", pufault, 1);
      chk("run blocked", run_cmd, 0);
      // indicator must show both levels over one flash period
      for (i = 0; i < 8; i++) begin
         cyc(16);
         seen[flash] = 1'b1;
      end
      chk("flash", seen, 2'b11);
      two_wire_run <= 1'b0;
      cyc(6);
      chk("pufault off", pufault, 0);
      chk("flash off", flash, 0);
      $display("test power-up done");
      // function codes: reset values, range limit, unmapped place
      for (i = 0; i < 8; i++) rd(OFS_FSEL0 + 8'(4*i), FSEL_RST[i], 0);
      wr(OFS_FSEL0, 32'h4a, 2'b10);
      rd(OFS_FSEL0, 32'h0, 0);
      wr(OFS_FSEL0, 32'h49, 0);
      rd(OFS_FSEL0, 32'h49, 0);
      rd(8'h38, 32'h0, 2'b10);
      $display("test registers done");
      // three-wire: terminal three gives direction
      wr(OFS_FSEL0 + 8'h08, 32'h2, 0);
      req <= 8'h03;
      cyc(3);
      chk("run early", run_cmd, 0);
      cyc(14);
      chk("run", run_cmd, 1);
      chk("fwd", reverse_cmd, 0);
      req <= 8'h06;
      cyc(8);
      chk("run kept", run_cmd, 1);
      chk("rev", reverse_cmd, 1);
      req <= 8'h04;
      cyc(1);
      req <= 8'h06;
      cyc(6);
      chk("stop", run_cmd, 0);
      req <= 8'h00;
      $display("test three-wire done");
      // location terminal, keypad key, freeze while running
      wr(OFS_FSEL0 + 8'h08, 32'h3, 0);
      wr(OFS_CTRL, 32'h8, 0);
      cyc(2);
      chk("remote", local_mode, 0);
      req <= 8'h04;
      cyc(6);
      chk("local", local_mode, 1);
      chk("led", local_led, 1);
      drive_running <= 1'b1;
      req <= 8'h00;
      cyc(6);
      chk("frozen", local_mode, 1);
      drive_running <= 1'b0;
      cyc(6);
      chk("deferred", local_mode, 0);
      $display("test location done");
      // source set terminal
      wr(OFS_FSEL0 + 8'h08, 32'h4, 0);
      wr(OFS_CTRL, 32'h0087_6500, 0);
      chk("fsrc1", fsrc, 5);
      chk("rsrc1", rsrc, 7);
      req <= 8'h04;
      cyc(6);
      chk("fsrc2", fsrc, 6);
      chk("rsrc2", rsrc, 8);
      chk("set2", set2, 1);
      drive_running <= 1'b1;
      req <= 8'h00;
      cyc(6);
      chk("set frozen", set2, 1);
      drive_running <= 1'b0;
      $display("test source done");
      // presets through terminals five to eight, then jog
      wr(OFS_FSEL0 + 8'h08, 32'h9, 0);
      wr(OFS_FSEL0 + 8'h18, 32'h7, 0);
      wr(OFS_FSEL0 + 8'h1c, 32'h8, 0);
      wr(OFS_PRESET0 + 8'(4*JOG_IDX), 32'habc, 0);
      for (i = 0; i < 16; i++) wr(OFS_PRESET0 + 8'(4*i), 32'h100 + i, 0);
      for (i = 0; i < 16; i++) begin
         req <= {4'(i), 4'h0};
         cyc(6);
         chk("preset", freq, 32'h100 + i);
      end
      req <= 8'h04;
      cyc(6);
      chk("jog freq", freq, 32'habc);
      chk("jog", jog, 1);
      $display("test presets done");
      // up/down terminals one and two, limits 1..3
      wr(OFS_FSEL0, 32'ha, 0);
      cyc(4);
      chk("alarm", alarm, 1);
      wr(OFS_FSEL0 + 8'h04, 32'hb, 0);
      cyc(4);
      chk("no alarm", alarm, 0);
      wr(OFS_CTRL, 32'h200, 0);
      wr(OFS_LIMITS, 32'h0001_0003, 0);
      two_wire_run <= 1'b1;
      drive_running <= 1'b1;
      req <= 8'h01;
      cyc(40);
      chk("up clamp", freq, 3);
      req <= 8'h03;
      cyc(20);
      chk("both hold", freq, 3);
      req <= 8'h02;
      cyc(40);
      chk("down clamp", freq, 1);
      req <= 8'h00;
      two_wire_run <= 1'b0;
      drive_running <= 1'b0;
      cyc(8);
      chk("cleared", freq, 0);
      // hold on: value kept after stop, cleared by a stopped press
      wr(OFS_CTRL, 32'h202, 0);
      two_wire_run <= 1'b1;
      req <= 8'h01;
      cyc(20);
      req <= 8'h00;
      cyc(6);
      two_wire_run <= 1'b0;
      cyc(6);
      chk("held", freq, 3);
      req <= 8'h02;
      cyc(8);
      chk("hold clear", freq, 0);
      req <= 8'h00;
      // source other than up/down: the step preset rules again
      wr(OFS_CTRL, 32'h100, 0);
      cyc(6);
      chk("no updn", freq, 32'h100);
      chk("set one", set2, 0);
      $display("test up/down done");
      summarize();
   end
endmodule
